//--- dram_front_regs.svh
`ifndef DRAM_FRONT_REGS_SVH
`define DRAM_FRONT_REGS_SVH

// register byte offsets on the control bus
`define REG_BANK_EN   8'h00
`define REG_EXT_BASE  8'h04
`define REG_STATUS    8'h08

// reset values
`define BANK_EN_RST   4'hf
`define EXT_BASE_RST  8'h00

// status word field positions
`define STAT_WIDEN    0
`define STAT_WAIT     1
`define STAT_REQ      2
`define STAT_LONG     3
`define STAT_BSEL     4
`define STAT_DEPOSIT  5
`define STAT_RAS_LO   8

// bus response codes
`define RESP_OKAY     2'b00
`define RESP_SLVERR   2'b10

`endif

//--- dram_front_pkg.sv
package dram_front_pkg;

	typedef enum logic {EDGE_RISE, EDGE_FALL} widen_edge_e;   // phi2 edge ending the widened sync
	typedef enum logic {CHIP_8K, CHIP_16K} chip_e;            // memory chip family
	typedef enum logic {XFER_8, XFER_8_16} xfer_e;            // bus transfer width mode
	typedef enum logic [1:0] {BEN_A15_LOW, BEN_A15_HIGH, BEN_ALWAYS, BEN_STATUS} bank_en_e;
	typedef enum logic [1:0] {WAIT_ANY, WAIT_M1, WAIT_NONE} wait_e;
	typedef enum logic {DEP_XRDY, DEP_DBIN} deposit_e;        // deposit qualifier

	// bus lines seen by the board
	typedef struct packed {
		logic        psync;     // sync pulse
		logic        phi2;      // phase-two bus clock
		logic        smemr;     // memory read status
		logic        sm1;       // instruction fetch status
		logic        sout;      // output status
		logic        sinp;      // input status
		logic        shlta;     // halt status
		logic        sinta;     // interrupt acknowledge status
		logic        phantom_n; // phantom, active low
		logic        error_n;   // error, active low
		logic        sxnreq_n;  // sixteen-bit request, active low
		logic        status_en; // status valid enable term
		logic        mwrite;    // memory write strobe
		logic        xrdy;      // panel ready
		logic        dbin;      // data bus in
		logic [15:0] addr;      // address lines
		logic [7:0]  ext_addr;  // extended address lines
	} bus_in_s;

	// memory front outputs
	typedef struct packed {
		logic       widened;      // widened sync pulse
		logic       refresh_stop; // hold the default-refresh count
		logic       wait_req;     // wait-state request
		logic       cycle_req;    // memory cycle request
		logic       long_cycle;   // stretch the memory cycle
		logic       board_sel;    // board selected
		logic       deposit;      // panel deposit detected
		logic       col_hi;       // shared high column address bit
		logic       col_sel;      // second selectable column bit
		logic [3:0] ras_sel;      // banks receiving the row strobe
	} mem_out_s;

endpackage : dram_front_pkg

//--- bus_sync.sv
`timescale 1ns/100ps
`default_nettype none

module bus_sync #(
	parameter int W = 1 // number of lines
)(
	input  wire logic         aclk,    // system clock
	input  wire logic         aresetn, // synchronous reset, active low
	input  wire logic [W-1:0] d,       // asynchronous lines
	output logic      [W-1:0] q,       // synchronized level
	output logic      [W-1:0] rise,    // one-cycle pulse on a rising level
	output logic      [W-1:0] fall     // one-cycle pulse on a falling level
);

	logic [W-1:0] s1_q; // first stage, read only by the second
	logic [W-1:0] s2_q; // second stage
	logic [W-1:0] s3_q; // delayed copy for edges

	// two-stage capture plus history
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
		end else begin
			s1_q <= d;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	assign q    = s2_q;
	assign rise = s2_q & ~s3_q;
	assign fall = ~s2_q & s3_q;

endmodule : bus_sync

`default_nettype wire

//--- s100_dram_cycle_select_config.sv
`timescale 1ns/100ps
`default_nettype none
`include "dram_front_regs.svh"
// Operation
// - hold refresh count while widened sync active
// - wait request comes from widened sync
// - widened sync ends on chosen phi2 edge
// - request latch optionally gated by board select
// - high column bit A13, else A0
// - second column bit A0, A14 or level
// - optional paired banks on sixteen-bit requests
// - bank low bit chosen by mode
// - upper bank bits depend on chip type
// - trigger on every sync or sync with read
// - long cycles only during memory read
// - error line optionally joins board select
// - wait on any cycle, fetch, or never
// - small chips enable on chosen A15 value
// - large chips always or status selected
// - extended compare optionally gates board select
// - deposit is write with ready or data-in
// - widened sync from sync start to edge
// - board select needs enabled bank and status

module s100_dram_cycle_select_config
	import dram_front_pkg::*;
#(
	parameter widen_edge_e sync_widen_edge_strap       = EDGE_RISE,  // ending edge
	parameter bit          request_select_gate_strap   = 1'b1,       // gate request by select
	parameter bit          column_address_source_strap = 1'b0,       // small-chip fixed level
	parameter bit          bank_decode_source_strap    = 1'b1,       // pair banks allowed
	parameter bit          sync_trigger_qualify_strap  = 1'b0,       // sync needs read status
	parameter bit          long_cycle_strap            = 1'b0,       // long cycles on reads
	parameter bit          error_input_strap           = 1'b0,       // error line used
	parameter wait_e       wait_mode_strap             = WAIT_NONE,  // wait generator mode
	parameter bank_en_e    bank_enable_source_strap    = BEN_ALWAYS, // bank enable source
	parameter bit          extended_compare_strap      = 1'b0,       // extended compare used
	parameter deposit_e    deposit_decode_strap        = DEP_XRDY,   // deposit qualifier
	parameter chip_e       chip_type                   = CHIP_16K,   // chip family
	parameter xfer_e       xfer_mode                   = XFER_8      // transfer width mode
)(
	input  wire logic       aclk,          // system clock
	input  wire logic       aresetn,       // synchronous reset, active low
	input  wire bus_in_s    bus_i,         // raw bus lines
	input  wire logic       cycle_clear,   // end of memory cycle, same clock
	output mem_out_s        mem_o,         // memory front outputs
	input  wire logic [7:0] s_axi_awaddr,  // write address
	input  wire logic       s_axi_awvalid, // write address valid
	output logic            s_axi_awready, // write address ready
	input  wire logic [31:0] s_axi_wdata,  // write data
	input  wire logic [3:0] s_axi_wstrb,   // write byte strobes
	input  wire logic       s_axi_wvalid,  // write data valid
	output logic            s_axi_wready,  // write data ready
	output logic [1:0]      s_axi_bresp,   // write response
	output logic            s_axi_bvalid,  // write response valid
	input  wire logic       s_axi_bready,  // write response ready
	input  wire logic [7:0] s_axi_araddr,  // read address
	input  wire logic       s_axi_arvalid, // read address valid
	output logic            s_axi_arready, // read address ready
	output logic [31:0]     s_axi_rdata,   // read data
	output logic [1:0]      s_axi_rresp,   // read response
	output logic            s_axi_rvalid,  // read data valid
	input  wire logic       s_axi_rready   // read data ready
);

	// offset is one of the mapped registers
	function automatic logic is_mapped(input logic [7:0] a);
		is_mapped = (a == `REG_BANK_EN) || (a == `REG_EXT_BASE) || (a == `REG_STATUS);
	endfunction : is_mapped

	// one-hot bank from a two-bit index
	function automatic logic [3:0] bank_onehot(input logic [1:0] idx);
		bank_onehot = 4'h1 << idx;
	endfunction : bank_onehot

	bus_in_s    bus_s;        // synchronized bus lines
	bus_in_s    bus_rise;     // rising edges
	bus_in_s    bus_fall;     // falling edges
	logic [3:0] bank_en_q;    // software bank enables
	logic [7:0] ext_base_q;   // extended address the board answers to
	logic       widen_q;      // widened sync
	logic       widen_d;
	logic       wait_q;       // wait request
	logic       wait_d;
	logic       req_q;        // cycle_request_flop
	logic       req_d;
	logic       long_q;       // long cycle
	logic       bsel_q;       // board select
	logic       bsel_d;
	logic       dep_q;        // deposit level
	logic       dep_d;
	logic       col_hi_q;     // high column bit
	logic       col_sel_q;    // selectable column bit
	logic       col_hi_d;
	logic       col_sel_d;
	logic [3:0] ras_q;        // bank strobe select
	logic [3:0] sel_d;        // decoded banks
	logic       widen_edge;   // configured phi2 edge
	logic       trig;         // memory cycle trigger
	logic       small_chip;   // 8K-type chips fitted
	logic       low_bit;      // bank decode low bit
	logic       up_bit;       // bank decode upper bit
	logic       bank_ok;      // bank enable condition
	logic       ext_match;    // extended_address_comparator result
	logic       status_clear; // no i/o, halt or acknowledge status, not phantom

	// every bus line is sampled twice before use
	bus_sync #(
		.W($bits(bus_in_s))
	) u_sync (
		.aclk    (aclk),
		.aresetn (aresetn),
		.d       (bus_i),
		.q       (bus_s),
		.rise    (bus_rise),
		.fall    (bus_fall)
	);

	// straps are fixed at build time and never change in operation
	assign small_chip = (chip_type == CHIP_8K);

	// widened sync: rises with sync, falls on the chosen phi2 edge after it
	assign widen_edge = (sync_widen_edge_strap == EDGE_RISE) ? bus_rise.phi2
	                                                       : bus_fall.phi2;
	always_comb begin
		if (bus_s.psync) begin
			widen_d = 1'b1;
		end else if (widen_q && widen_edge) begin
			widen_d = 1'b0;
		end else begin
			widen_d = widen_q;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			widen_q <= 1'b0;
		end else begin
			widen_q <= widen_d;
		end
	end

	// bank decode bits per chip type and transfer width
	always_comb begin
		if (xfer_mode == XFER_8_16) begin
			low_bit = bus_s.addr[0];
		end else if (small_chip) begin
			low_bit = bus_s.addr[13];
		end else begin
			low_bit = bus_s.addr[14];
		end
		up_bit = small_chip ? bus_s.addr[14] : bus_s.addr[15];
		if (small_chip) begin
			// enable on the chosen half of the space
			bank_ok = bus_s.addr[15] == (bank_enable_source_strap == BEN_A15_HIGH);
		end else if (bank_enable_source_strap == BEN_ALWAYS) begin
			bank_ok = 1'b1;
		end else begin
			// status enable must already be valid at the trigger
			bank_ok = bus_s.status_en;
		end
	end

	// single or paired bank selection
	always_comb begin
		if (!bank_ok) begin
			sel_d = 4'h0;
		end else if (bank_decode_source_strap && !bus_s.sxnreq_n) begin
			sel_d = up_bit ? 4'hc : 4'h3;
		end else begin
			sel_d = bank_onehot({low_bit, up_bit});
		end
	end

	// board select qualifiers
	assign ext_match    = (bus_s.ext_addr == ext_base_q);
	assign status_clear = !bus_s.sout && !bus_s.sinp && !bus_s.shlta && !bus_s.sinta
	                      && bus_s.phantom_n;
	always_comb begin
		bsel_d = (|(sel_d & bank_en_q)) && status_clear;
		if (error_input_strap && !bus_s.error_n) begin
			bsel_d = 1'b0;
		end
		if (extended_compare_strap && !ext_match) begin
			bsel_d = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bsel_q <= 1'b0;
			ras_q  <= 4'h0;
		end else begin
			bsel_q <= bsel_d;
			ras_q  <= bsel_d ? sel_d : 4'h0;
		end
	end

	// wait request taken from the widened sync, qualified by mode
	always_comb begin
		case (wait_mode_strap)
			WAIT_ANY: begin
				wait_d = widen_d && bsel_d;
			end
			WAIT_M1: begin
				wait_d = widen_d && bsel_d && bus_s.sm1;
			end
			default: begin
				wait_d = 1'b0;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wait_q <= 1'b0;
		end else begin
			wait_q <= wait_d;
		end
	end

	// panel deposit level
	assign dep_d = bus_s.mwrite && ((deposit_decode_strap == DEP_XRDY) ? bus_s.xrdy
	                                                                 : bus_s.dbin);
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dep_q <= 1'b0;
		end else begin
			dep_q <= dep_d;
		end
	end

	// sync or deposit trigger
	assign trig = (bus_rise.psync && (!sync_trigger_qualify_strap || bus_s.smemr))
	              || (dep_d && !dep_q);

	// request latch: a new trigger wins over the end-of-cycle clear
	always_comb begin
		if (trig && (!request_select_gate_strap || bsel_d)) begin
			req_d = 1'b1;
		end else if (cycle_clear) begin
			req_d = 1'b0;
		end else begin
			req_d = req_q;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			req_q  <= 1'b0;
			long_q <= 1'b0;
		end else begin
			req_q  <= req_d;
			long_q <= long_cycle_strap && bus_s.smemr && req_d;
		end
	end

	// column address bits presented during the column strobe
	always_comb begin
		col_hi_d = (xfer_mode == XFER_8 && small_chip) ? bus_s.addr[0] : bus_s.addr[13];
		if (small_chip) begin
			col_sel_d = column_address_source_strap;
		end else if (xfer_mode == XFER_8) begin
			col_sel_d = bus_s.addr[0];
		end else begin
			col_sel_d = bus_s.addr[14];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			col_hi_q  <= 1'b0;
			col_sel_q <= 1'b0;
		end else begin
			col_hi_q  <= col_hi_d;
			col_sel_q <= col_sel_d;
		end
	end

	// outputs, all straight from flops
	assign mem_o.widened      = widen_q;
	assign mem_o.refresh_stop = widen_q;
	assign mem_o.wait_req     = wait_q;
	assign mem_o.cycle_req    = req_q;
	assign mem_o.long_cycle   = long_q;
	assign mem_o.board_sel    = bsel_q;
	assign mem_o.deposit      = dep_q;
	assign mem_o.col_hi       = col_hi_q;
	assign mem_o.col_sel      = col_sel_q;
	assign mem_o.ras_sel      = ras_q;

	// control bus slave
	logic       aw_full_q;  // write address held
	logic       w_full_q;   // write data held
	logic [7:0] awaddr_q;   // held write address
	logic [31:0] wdata_q;   // held write data
	logic [3:0] wstrb_q;    // held strobes
	logic       wr_go;      // both halves present, perform write
	logic       bvalid_d;
	logic       aw_full_d;
	logic       w_full_d;

	assign wr_go     = aw_full_q && w_full_q && !s_axi_bvalid;
	assign aw_full_d = wr_go ? 1'b0 : (aw_full_q || (s_axi_awvalid && s_axi_awready));
	assign w_full_d  = wr_go ? 1'b0 : (w_full_q || (s_axi_wvalid && s_axi_wready));
	assign bvalid_d  = wr_go || (s_axi_bvalid && !s_axi_bready);

	// write channel capture and response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_q     <= 1'b0;
			w_full_q      <= 1'b0;
			awaddr_q      <= 8'h00;
			wdata_q       <= 32'h0000_0000;
			wstrb_q       <= 4'h0;
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `RESP_OKAY;
		end else begin
			aw_full_q     <= aw_full_d;
			w_full_q      <= w_full_d;
			s_axi_awready <= !aw_full_d && !bvalid_d;
			s_axi_wready  <= !w_full_d && !bvalid_d;
			s_axi_bvalid  <= bvalid_d;
			if (s_axi_awvalid && s_axi_awready) begin
				awaddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			if (wr_go) begin
				s_axi_bresp <= is_mapped(awaddr_q) ? `RESP_OKAY : `RESP_SLVERR;
			end
		end
	end

	// software registers steering bank enable and the extended compare
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bank_en_q  <= `BANK_EN_RST;
			ext_base_q <= `EXT_BASE_RST;
		end else if (wr_go && wstrb_q[0]) begin
			if (awaddr_q == `REG_BANK_EN) begin
				bank_en_q <= wdata_q[3:0];
			end else if (awaddr_q == `REG_EXT_BASE) begin
				ext_base_q <= wdata_q[7:0];
			end
		end
	end

	// read channel, answer one cycle after the address is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rresp   <= is_mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
			s_axi_rdata   <= 32'h0000_0000;
			if (s_axi_araddr == `REG_BANK_EN) begin
				s_axi_rdata[3:0] <= bank_en_q;
			end else if (s_axi_araddr == `REG_EXT_BASE) begin
				s_axi_rdata[7:0] <= ext_base_q;
			end else if (s_axi_araddr == `REG_STATUS) begin
				s_axi_rdata[`STAT_WIDEN]   <= widen_q;
				s_axi_rdata[`STAT_WAIT]    <= wait_q;
				s_axi_rdata[`STAT_REQ]     <= req_q;
				s_axi_rdata[`STAT_LONG]    <= long_q;
				s_axi_rdata[`STAT_BSEL]    <= bsel_q;
				s_axi_rdata[`STAT_DEPOSIT] <= dep_q;
				s_axi_rdata[`STAT_RAS_LO +: 4] <= ras_q;
			end
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
		end
	end

	// checks on the front logic
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	sequence s_sync_seen;
		bus_s.psync;
	endsequence

	sequence s_widen_close;
		!bus_s.psync && widen_q && widen_edge;
	endsequence

	AST_REFRESH_HOLD: assert property (s_sync_seen |=> mem_o.refresh_stop)
		else $error("refresh count not held during sync");
	AST_WAIT_SOURCE: assert property (wait_q |-> widen_q && bsel_q)
		else $error("wait request without widened sync");
	AST_WIDEN_END: assert property (s_widen_close |=> !widen_q)
		else $error("widened sync did not end on the chosen edge");
	AST_WIDEN_START: assert property (s_sync_seen ##1 s_sync_seen |-> widen_q)
		else $error("widened sync not active during sync");
	AST_REQ_GATE: assert property (request_select_gate_strap && !$past(req_q) && req_q
		|-> $past(bsel_d))
		else $error("request latched without board select");
	AST_COL_HI: assert property (1'b1 |=> col_hi_q == ((xfer_mode == XFER_8 && small_chip)
		? $past(bus_s.addr[0]) : $past(bus_s.addr[13])))
		else $error("wrong high column bit");
	AST_WAIT_MODE: assert property (wait_q |-> wait_mode_strap != WAIT_NONE
		&& (wait_mode_strap != WAIT_M1 || $past(bus_s.sm1)))
		else $error("wait request outside chosen mode");
	AST_LONG: assert property (long_q |-> long_cycle_strap && $past(bus_s.smemr))
		else $error("long cycle outside memory read");
	AST_BSEL: assert property (bsel_q |-> $past(status_clear))
		else $error("board selected with bad status");
	AST_DEPOSIT: assert property (dep_q |-> $past(bus_s.mwrite))
		else $error("deposit without memory write");
	// two banks only for a sixteen-bit request with pairing on, else exactly one
	AST_PAIR: assert property (ras_q != 4'h0 |-> $countones(ras_q)
		== ((bank_decode_source_strap && !$past(bus_s.sxnreq_n)) ? 2 : 1))
		else $error("wrong number of banks selected");

endmodule : s100_dram_cycle_select_config

`default_nettype wire

//--- bus_master_model.sv
`timescale 1ns/100ps
`default_nettype none

module bus_master_model
	import dram_front_pkg::*;
(
	output var bus_in_s bus_o // bus lines driven toward the board
);
	// idle bus, then a free-running bus clock unrelated to the system clock
	initial begin
		bus_o = '0;
		bus_o.phantom_n = 1'b1;
		bus_o.error_n = 1'b1;
		bus_o.sxnreq_n = 1'b1;
		bus_o.status_en = 1'b1;
		#7;
		forever #160 bus_o.phi2 = ~bus_o.phi2;
	end

	// one bus cycle: status first, then one sync pulse, then release
	task automatic cycle(input logic [15:0] a, input logic rd, sxn_n, err_n, io);
		@(negedge bus_o.phi2);
		bus_o.addr = a;
		bus_o.smemr = rd;
		bus_o.sm1 = rd;
		bus_o.sout = io;
		bus_o.sxnreq_n = sxn_n;
		bus_o.error_n = err_n;
		@(posedge bus_o.phi2);
		bus_o.psync = 1'b1;
		@(posedge bus_o.phi2);
		bus_o.psync = 1'b0;
		repeat (2) @(posedge bus_o.phi2);
		// released address shows the inverse so stale values cannot pass
		bus_o.addr = ~a;
		bus_o.smemr = 1'b0;
		bus_o.sm1 = 1'b0;
		bus_o.sout = 1'b0;
		bus_o.sxnreq_n = 1'b1;
		bus_o.error_n = 1'b1;
	endtask : cycle

	// front panel strobes
	task automatic panel(input logic mw, xr, db);
		bus_o.mwrite = mw;
		bus_o.xrdy = xr;
		bus_o.dbin = db;
	endtask : panel
endmodule : bus_master_model

`default_nettype wire

//--- tb_s100_dram_cycle_select_config.sv
`timescale 1ns/100ps
`default_nettype none
`include "dram_front_regs.svh"

module tb_s100_dram_cycle_select_config
	import dram_front_pkg::*;
;
	logic        aclk, aresetn, cycle_clear;           // clock, reset, cycle end
	bus_in_s     bus_i;                                // bus lines from the model
	mem_out_s    mem_o;                                // memory front outputs
	mem_out_s    mem2;                                 // outputs of the alternate build
	logic [7:0]  awaddr, araddr;                       // bus addresses
	logic [31:0] wdata, rdata;                         // bus data
	logic        awvalid, wvalid, bready, arvalid, rready; // master strobes
	logic        awready, wready, bvalid, arready, rvalid; // slave strobes
	logic [1:0]  bresp, rresp;                         // responses
	int          fails, n_compared, cyc;               // counters

	bus_master_model bus_master_model_inst (.bus_o(bus_i));

	// wider edge, long cycles, error line, waits and extended compare all on
	s100_dram_cycle_select_config #(
		.sync_widen_edge_strap(EDGE_FALL), .long_cycle_strap(1'b1),
		.error_input_strap(1'b1), .wait_mode_strap(WAIT_ANY), .extended_compare_strap(1'b1)
	) s100_dram_cycle_select_config_inst (
		.aclk(aclk), .aresetn(aresetn), .bus_i(bus_i), .cycle_clear(cycle_clear),
		.mem_o(mem_o), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
	);

	// alternate build: each strap at its other setting, register port idle
	s100_dram_cycle_select_config #(
		.sync_widen_edge_strap(EDGE_RISE), .request_select_gate_strap(1'b0),
		.column_address_source_strap(1'b1), .bank_decode_source_strap(1'b0),
		.sync_trigger_qualify_strap(1'b1), .wait_mode_strap(WAIT_M1),
		.bank_enable_source_strap(BEN_A15_HIGH), .deposit_decode_strap(DEP_DBIN),
		.chip_type(CHIP_8K), .xfer_mode(XFER_8_16)
	) s100_dram_cycle_select_config_alt_inst (
		.aclk(aclk), .aresetn(aresetn), .bus_i(bus_i), .cycle_clear(cycle_clear),
		.mem_o(mem2), .s_axi_awaddr(8'h00), .s_axi_awvalid(1'b0), .s_axi_awready(),
		.s_axi_wdata(32'h0000_0000), .s_axi_wstrb(4'h0), .s_axi_wvalid(1'b0),
		.s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(), .s_axi_bready(1'b0),
		.s_axi_araddr(8'h00), .s_axi_arvalid(1'b0), .s_axi_arready(), .s_axi_rdata(),
		.s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready(1'b0)
	);

	// system clock, 40 ns
	initial begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end

	// cut a hang short
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			tally_and_finish();
		end
	end

	task automatic tally_and_finish;
		$display("compared %0d, failed %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : tally_and_finish

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// register write, waits for the response
	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		// only the bench timeout ends this wait
		do begin
			@(posedge aclk);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		bready <= 1'b0;
		chk(bvalid, 1'b1);
		chk(bresp, r);
	endtask : axw

	// register read, compares data and response
	task automatic axr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		// only the bench timeout ends this wait
		do begin
			@(posedge aclk);
			if (arready === 1'b1) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rready <= 1'b0;
		chk(rvalid, 1'b1);
		chk(rdata, d);
		chk(rresp, r);
	endtask : axr

	// end the latched memory cycle request
	task automatic clear_req;
		@(posedge aclk);
		cycle_clear <= 1'b1;
		@(posedge aclk);
		cycle_clear <= 1'b0;
		repeat (2) @(negedge aclk);
		chk(mem_o.cycle_req, 1'b0);
		chk(mem2.cycle_req, 1'b0);
	endtask : clear_req

	// one bus cycle from the model, judged while the widened sync stands
	task automatic mcyc(input logic [15:0] a, input logic rd, sxn_n, err_n, io, sel,
		input logic [3:0] ras);
		int n;
		@(posedge aclk);
		fork
			bus_master_model_inst.cycle(a, rd, sxn_n, err_n, io);
			begin
				for (n = 0; n < 200 && mem_o.widened !== 1'b1; n++) @(negedge aclk);
				chk(mem_o.refresh_stop, 1'b1);
				chk(mem_o.board_sel, sel);
				chk(mem_o.ras_sel, ras);
				chk(mem_o.wait_req, sel);
				chk(mem_o.cycle_req, sel);
				chk(mem_o.long_cycle, rd & sel);
				chk(mem_o.col_hi, a[13]);
				chk(mem_o.col_sel, a[0]);
				chk(mem2.board_sel, a[15] & ~io);
				chk(mem2.ras_sel, (a[15] & ~io) ? 4'h1 << {a[0], a[14]} : 4'h0);
				chk(mem2.cycle_req, rd);
				chk(mem2.wait_req, rd & a[15] & ~io);
				chk(mem2.long_cycle, 1'b0);
				chk(mem2.col_hi, a[13]);
				chk(mem2.col_sel, 1'b1);
				for (n = 0; n < 200 && mem_o.widened !== 1'b0; n++) @(negedge aclk);
				chk(bus_i.phi2, 1'b0);
				chk(mem2.widened, 1'b0);
				chk(mem_o.cycle_req, sel);
			end
		join
		clear_req();
	endtask : mcyc

	// reset values, access kinds and the unmapped place
	task automatic t_regs;
		axr(`REG_BANK_EN, `BANK_EN_RST, `RESP_OKAY);
		axr(`REG_EXT_BASE, `EXT_BASE_RST, `RESP_OKAY);
		axr(8'h0c, 32'h0, `RESP_SLVERR);
		axw(8'h0c, 32'h5, `RESP_SLVERR);
		axw(`REG_STATUS, 32'hff, `RESP_OKAY);
		axw(`REG_BANK_EN, 32'h5, `RESP_OKAY);
		axr(`REG_BANK_EN, 32'h5, `RESP_OKAY);
		axw(`REG_BANK_EN, 32'hf, `RESP_OKAY);
	endtask : t_regs

	// bank decode, pairing and the error, output status, bank enable and extended compare deselects
	task automatic t_select;
		mcyc(16'h2001, 1, 1, 1, 0, 1, 4'b0001);
		mcyc(16'hc000, 0, 1, 1, 0, 1, 4'b1000);
		mcyc(16'h8000, 1, 0, 1, 0, 1, 4'b1100);
		mcyc(16'h2001, 1, 1, 0, 0, 0, 4'b0000);
		mcyc(16'h2001, 0, 1, 1, 1, 0, 4'b0000);
		axw(`REG_BANK_EN, 32'he, `RESP_OKAY);
		mcyc(16'h2001, 1, 1, 1, 0, 0, 4'b0000);
		axw(`REG_BANK_EN, 32'hf, `RESP_OKAY);
		axw(`REG_EXT_BASE, 32'h5a, `RESP_OKAY);
		mcyc(16'h2001, 1, 1, 1, 0, 0, 4'b0000);
		axw(`REG_EXT_BASE, 32'h0, `RESP_OKAY);
	endtask : t_select

	// panel deposit with ready counts in the main build, with data-in only in the alternate build
	task automatic t_deposit;
		bus_master_model_inst.panel(1, 1, 0);
		repeat (4) @(negedge aclk);
		chk(mem_o.deposit, 1'b1);
		chk(mem_o.cycle_req, 1'b1);
		chk(mem2.deposit, 1'b0);
		// status word: bank four selected, request and deposit set
		axr(`REG_STATUS, 32'h0000_0834, `RESP_OKAY);
		bus_master_model_inst.panel(0, 0, 0);
		clear_req();
		bus_master_model_inst.panel(1, 0, 1);
		repeat (4) @(negedge aclk);
		chk(mem_o.deposit, 1'b0);
		chk(mem2.deposit, 1'b1);
		chk(mem2.cycle_req, 1'b1);
		bus_master_model_inst.panel(0, 0, 0);
		clear_req();
	endtask : t_deposit

	// every input set at time zero, reset for two cycles, then the scenarios
	initial begin
		{aresetn, cycle_clear, awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wdata} = '0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		t_regs();
		t_select();
		t_deposit();
		tally_and_finish();
	end
endmodule : tb_s100_dram_cycle_select_config

`default_nettype wire
